/* File: verilog/rtc_ctrl_defines.svh */
`ifndef RTC_CTRL_DEFINES_SVH
`define RTC_CTRL_DEFINES_SVH

// register indices; byte address is four times the index
`define RTC_IDX_OSC      6'h0a
`define RTC_IDX_CFG      6'h0b
`define RTC_IDX_EVT      6'h0c
`define RTC_IDX_VALID    6'h0d

// oscillator/rate register fields
`define OSC_BUSY_BIT     7
`define OSC_FIELD_HI     6
`define OSC_FIELD_LO     4
`define OSC_WRITE_MASK   8'h7f
`define OSC_EVT_WRITABLE 3'h3

// time_config_reg fields
`define CFG_UTI          7
`define CFG_PIE          6
`define CFG_AIE          5
`define CFG_UIE          4
`define CFG_WAVE_OUT_ENABLE         3
`define CFG_DF           2
`define CFG_HF           1
`define CFG_DSE          0

// event_status_reg fields
`define EVT_IRQ_REQUEST_FLAG         7
`define EVT_PF           6
`define EVT_AF           5
`define EVT_UF           4
`define EVT_KOUT         2
`define EVT_USED_MASK    8'hf4

// integrity_status_reg fields
`define VALID_BIT        7

// reset values
`define OSC_RESET        8'h00
`define CFG_RESET        8'h00
`define EVT_RESET        8'h00

// calendar constants for summer time
`define CAL_OCTOBER      8'h0a
`define CAL_APRIL        8'h04
`define CAL_SUNDAY       8'h01
`define CAL_LAST_WEEK    8'h19
`define CAL_FIRST_WEEK   8'h07
`define CAL_HOUR_ONE     8'h01
`define CAL_FIFTY_NINE   8'h3b

`endif

/* File: verilog/rtc_ctrl_pkg.sv */
package rtc_ctrl_pkg;

  // fall-back happens only once per day, so the repeated hour does not loop
  typedef enum logic [1:0] {
    DST_ARMED = 2'b01,
    DST_HELD  = 2'b10
  } dst_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage : rtc_ctrl_pkg

/* File: verilog/rtc_ctrl_regs.sv */
// Behaviour
// R01: october last sunday, 1:59:59 falls back once
// R02: april first sunday, 2:00 jumps to 3:00
// R03: hour format bit, 1 = 24h, 0 = 12h
// R04: number format bit, 1 = binary, 0 = bcd
// R05: wave enable drives output, else held low
// R06: update irq only while update enable set
// R07: copy inhibit forces update enable clear
// R08: alarm irq only while alarm enable set
// R09: periodic irq only while periodic enable set
// R10: copy inhibit blocks counter to buffer copy
// R11: event status read-only, bits 3,1,0 zero
// R12: crystal enable settable only with osc 011
// R13: both enables give crystal wave output
// R14: update flag set per update, read clears
// R15: alarm flag set on alarm, read clears
// R16: periodic flag set per period, read clears
// R17: irq flag set on enabled flag, read clears
// R18: integrity register read-only, bits 6:0 zero
// R19: valid bit shows backup source health
// R20: osc field bits 6:4, 011 acts as 010
// R21: event status writable only with osc 011
// R22: irq pin low while irq flag set
// R23: read returns pre-clear flags, clear afterwards
//
// Register access over APB and the address map are this design's own decisions.
`include "rtc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_regs (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_update_busy,
  input  wire logic        i_update_end,
  input  wire logic        i_alarm_event,
  input  wire logic        i_periodic_event,
  input  wire logic        i_second_tick,
  input  wire logic [7:0]  i_cal_hour,
  input  wire logic [7:0]  i_cal_min,
  input  wire logic [7:0]  i_cal_sec,
  input  wire logic [7:0]  i_cal_dow,
  input  wire logic [7:0]  i_cal_date,
  input  wire logic [7:0]  i_cal_month,
  input  wire logic        i_rate_wave,
  input  wire logic        i_crystal_wave,
  input  wire logic        i_backup_valid,
  output logic             o_irq_n,
  output logic             o_wave_out_pin,
  output logic             o_update_copy_allow,
  output logic             o_hour_format_sel,
  output logic             o_number_format_sel,
  output logic [3:0]       o_rate_select,
  output logic [2:0]       o_osc_control_field,
  output logic             o_dst_fall_back,
  output logic             o_dst_spring_forward
);

  // calendar byte to binary, honouring the number format
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin_mode);
    logic [7:0] tens;
    tens = {4'h0, v[7:4]};
    to_bin = bin_mode ? v : 8'((tens << 3) + (tens << 1) + {4'h0, v[3:0]});
  endfunction : to_bin

  // register state
  rtc_ctrl_pkg::reg_byte_t osc_r, osc_nxt;
  rtc_ctrl_pkg::reg_byte_t cfg_r, cfg_nxt;
  rtc_ctrl_pkg::reg_byte_t evt_r, evt_nxt;
  logic [31:0]             prdata_r, prdata_nxt;
  logic                    pready_r, pready_nxt;
  logic                    pslverr_r, pslverr_nxt;
  logic                    rd_evt_r, rd_evt_nxt;
  logic                    irq_n_r, copy_r, wave_r;
  logic                    valid_s1_r, valid_s2_r;

  // bus decode
  logic       setup;
  logic       access_done;
  logic [5:0] idx;
  logic       mapped;
  logic       osc_is_011;
  logic [2:0] osc_field_nxt;
  logic       irq_cond;

  assign setup       = i_psel & ~i_penable;
  assign access_done = i_psel & i_penable & pready_r;
  assign idx         = i_paddr[7:2];
  assign mapped      = (idx == `RTC_IDX_OSC) | (idx == `RTC_IDX_CFG) |
                       (idx == `RTC_IDX_EVT) | (idx == `RTC_IDX_VALID);
  assign osc_is_011  = (osc_r[`OSC_FIELD_HI:`OSC_FIELD_LO] == `OSC_EVT_WRITABLE);

  // apb: read data and pready captured at the setup edge, so every access has no wait state
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
    rd_evt_nxt  = setup & ~i_pwrite & (idx == `RTC_IDX_EVT);
    prdata_nxt  = 32'h00000000;
    if (setup & ~i_pwrite) begin
      case (idx)
        `RTC_IDX_OSC:   prdata_nxt = {24'h000000, i_update_busy & ~cfg_r[`CFG_UTI], osc_r[6:0]};
        `RTC_IDX_CFG:   prdata_nxt = {24'h000000, cfg_r};
        `RTC_IDX_EVT:   prdata_nxt = {24'h000000, evt_r & `EVT_USED_MASK}; // [R11] [R23]
        `RTC_IDX_VALID: prdata_nxt = {24'h000000, valid_s2_r, 7'h00};     // [R18] [R19]
        default:        prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // oscillator/rate and time config registers
  always_comb begin
    osc_nxt = osc_r;
    cfg_nxt = cfg_r;
    if (access_done & i_pwrite & (idx == `RTC_IDX_OSC)) begin
      osc_nxt = (osc_r & ~`OSC_WRITE_MASK) | (i_pwdata[7:0] & `OSC_WRITE_MASK); // [R20]
    end
    if (access_done & i_pwrite & (idx == `RTC_IDX_CFG)) begin
      cfg_nxt = i_pwdata[7:0]; // [R03] [R04]
    end
    if (cfg_nxt[`CFG_UTI]) begin
      cfg_nxt[`CFG_UIE] = 1'b0; // [R07]
    end
    osc_nxt[`OSC_BUSY_BIT] = 1'b0;
  end

  assign osc_field_nxt = osc_nxt[`OSC_FIELD_HI:`OSC_FIELD_LO];

  // event flags: a set always beats the read clear, and only flags actually returned are cleared
  always_comb begin
    evt_nxt = evt_r;
    if (rd_evt_r & access_done) begin
      evt_nxt[`EVT_IRQ_REQUEST_FLAG] = evt_r[`EVT_IRQ_REQUEST_FLAG] & ~prdata_r[`EVT_IRQ_REQUEST_FLAG]; // [R17] [R23]
      evt_nxt[`EVT_PF]   = evt_r[`EVT_PF] & ~prdata_r[`EVT_PF];     // [R16]
      evt_nxt[`EVT_AF]   = evt_r[`EVT_AF] & ~prdata_r[`EVT_AF];     // [R15]
      evt_nxt[`EVT_UF]   = evt_r[`EVT_UF] & ~prdata_r[`EVT_UF];     // [R14]
    end
    if (access_done & i_pwrite & (idx == `RTC_IDX_EVT) & osc_is_011) begin
      evt_nxt = i_pwdata[7:0] & `EVT_USED_MASK; // [R21]
    end
    if (i_update_end) begin
      evt_nxt[`EVT_UF] = 1'b1; // [R14]
    end
    if (i_alarm_event) begin
      evt_nxt[`EVT_AF] = 1'b1; // [R15]
    end
    if (i_periodic_event) begin
      evt_nxt[`EVT_PF] = 1'b1; // [R16]
    end
    irq_cond = (evt_nxt[`EVT_AF] & cfg_nxt[`CFG_AIE]) |                // [R08]
               (evt_nxt[`EVT_PF] & cfg_nxt[`CFG_PIE]) |                // [R09]
               (evt_nxt[`EVT_UF] & cfg_nxt[`CFG_UIE]);                 // [R06]
    if (irq_cond & ~(rd_evt_r & access_done)) begin
      evt_nxt[`EVT_IRQ_REQUEST_FLAG] = 1'b1; // [R17]
    end
    if (irq_cond & (i_update_end | i_alarm_event | i_periodic_event)) begin
      evt_nxt[`EVT_IRQ_REQUEST_FLAG] = 1'b1; // new event wins over the read clear
    end
    if (osc_field_nxt != `OSC_EVT_WRITABLE) begin
      evt_nxt[`EVT_KOUT] = 1'b0; // [R12]
    end
    evt_nxt = evt_nxt & `EVT_USED_MASK; // [R11]
  end

  // register everything
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      osc_r     <= `OSC_RESET;
      cfg_r     <= `CFG_RESET;
      evt_r     <= `EVT_RESET;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      rd_evt_r  <= 1'b0;
      irq_n_r   <= 1'b1;
      copy_r    <= 1'b1;
      wave_r    <= 1'b0;
    end else begin
      osc_r     <= osc_nxt;
      cfg_r     <= cfg_nxt;
      evt_r     <= evt_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      rd_evt_r  <= rd_evt_nxt;
      irq_n_r   <= ~evt_nxt[`EVT_IRQ_REQUEST_FLAG];     // [R22]
      copy_r    <= ~cfg_nxt[`CFG_UTI];      // [R10]
      wave_r    <= cfg_r[`CFG_WAVE_OUT_ENABLE] &       // [R05]
                   (evt_r[`EVT_KOUT] ? i_crystal_wave : i_rate_wave); // [R13]
    end
  end

  // backup-valid comes from an analogue comparator, so synchronise it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      valid_s1_r <= 1'b0;
      valid_s2_r <= 1'b0;
    end else begin
      valid_s1_r <= i_backup_valid;
      valid_s2_r <= valid_s1_r;
    end
  end

  // summer time: decisions taken on the tick at which 1:59:59 would advance
  rtc_ctrl_pkg::dst_state_t dst_r, dst_nxt;
  logic fall_r, fall_nxt, spring_r, spring_nxt;
  logic bin_mode, hour_am, at_last_sec, oct_last_sun, apr_first_sun;
  logic [7:0] hour_b, min_b, sec_b, date_b, month_b, dow_b;

  assign bin_mode = cfg_r[`CFG_DF];
  assign hour_am  = cfg_r[`CFG_HF] | ~i_cal_hour[7]; // 12h mode keeps the pm flag in bit 7
  assign hour_b   = to_bin({1'b0, i_cal_hour[6:0]}, bin_mode);
  assign min_b    = to_bin(i_cal_min, bin_mode);
  assign sec_b    = to_bin(i_cal_sec, bin_mode);
  assign date_b   = to_bin(i_cal_date, bin_mode);
  assign month_b  = to_bin(i_cal_month, bin_mode);
  assign dow_b    = to_bin(i_cal_dow, bin_mode);

  always_comb begin
    at_last_sec   = hour_am & (hour_b == `CAL_HOUR_ONE) &
                    (min_b == `CAL_FIFTY_NINE) & (sec_b == `CAL_FIFTY_NINE);
    oct_last_sun  = (month_b == `CAL_OCTOBER) & (dow_b == `CAL_SUNDAY) &
                    (date_b >= `CAL_LAST_WEEK);
    apr_first_sun = (month_b == `CAL_APRIL) & (dow_b == `CAL_SUNDAY) &
                    (date_b <= `CAL_FIRST_WEEK);
    fall_nxt      = 1'b0;
    spring_nxt    = cfg_r[`CFG_DSE] & i_second_tick & apr_first_sun & at_last_sec; // [R02]
    dst_nxt       = dst_r;
    case (dst_r)
      rtc_ctrl_pkg::DST_ARMED: begin
        if (cfg_r[`CFG_DSE] & i_second_tick & oct_last_sun & at_last_sec) begin
          fall_nxt = 1'b1; // [R01]
          dst_nxt  = rtc_ctrl_pkg::DST_HELD;
        end
      end
      rtc_ctrl_pkg::DST_HELD: begin
        if (~oct_last_sun) begin
          dst_nxt = rtc_ctrl_pkg::DST_ARMED; // re-arm once the day is over
        end
      end
      default: dst_nxt = rtc_ctrl_pkg::DST_ARMED;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      dst_r    <= rtc_ctrl_pkg::DST_ARMED;
      fall_r   <= 1'b0;
      spring_r <= 1'b0;
    end else begin
      dst_r    <= dst_nxt;
      fall_r   <= fall_nxt;
      spring_r <= spring_nxt;
    end
  end

  // outputs, all straight from flops
  assign o_prdata             = prdata_r;
  assign o_pready             = pready_r;
  assign o_pslverr            = pslverr_r;
  assign o_irq_n              = irq_n_r;
  assign o_wave_out_pin       = wave_r;
  assign o_update_copy_allow  = copy_r;
  assign o_hour_format_sel    = cfg_r[`CFG_HF];
  assign o_number_format_sel  = cfg_r[`CFG_DF];
  assign o_rate_select        = osc_r[3:0];
  assign o_osc_control_field  = osc_r[`OSC_FIELD_HI:`OSC_FIELD_LO];
  assign o_dst_fall_back      = fall_r;
  assign o_dst_spring_forward = spring_r;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_uie_inhibited: assert property (cfg_r[`CFG_UTI] |-> !cfg_r[`CFG_UIE]) // [R07]
    else $error("update enable set while copy inhibited");
  a_copy_follows: assert property (o_update_copy_allow == !cfg_r[`CFG_UTI]) // [R10]
    else $error("copy allow disagrees with inhibit bit");
  a_irq_pin: assert property (o_irq_n == !evt_r[`EVT_IRQ_REQUEST_FLAG]) // [R22]
    else $error("irq pin disagrees with irq flag");
  a_alarm_sets: assert property (i_alarm_event |=> evt_r[`EVT_AF]) // [R15]
    else $error("alarm event lost");
  a_update_irq: assert property (i_update_end && cfg_r[`CFG_UIE] && !cfg_r[`CFG_UTI]
    && !(access_done && i_pwrite) |=> evt_r[`EVT_IRQ_REQUEST_FLAG] ##1 !o_irq_n) // [R06]
    else $error("enabled update event gave no irq");
  a_masked_quiet: assert property (cfg_r[6:4] == 3'h0 && !evt_r[`EVT_IRQ_REQUEST_FLAG] && !osc_is_011
    && !(access_done && i_pwrite) |=> !evt_r[`EVT_IRQ_REQUEST_FLAG]) // [R17]
    else $error("irq flag set with all enables off");
  a_read_clears: assert property (rd_evt_r && access_done && prdata_r[`EVT_PF]
    && !i_periodic_event |=> !evt_r[`EVT_PF]) // [R16]
    else $error("periodic flag survived read");
  a_read_order: assert property (rd_evt_r && access_done |-> prdata_r[7:0] ==
    $past(evt_r & `EVT_USED_MASK)) // [R23]
    else $error("read data not taken before clear");
  a_zero_bits: assert property (evt_r[3] == 1'b0 && evt_r[1:0] == 2'h0) // [R11]
    else $error("unused event bits set");
  a_kout_gate: assert property (!osc_is_011 |-> !evt_r[`EVT_KOUT]) // [R12]
    else $error("crystal enable set without osc 011");
  a_wave_low: assert property (!cfg_r[`CFG_WAVE_OUT_ENABLE] |=> !o_wave_out_pin) // [R05]
    else $error("wave pin driven while disabled");
  a_fall_once: assert property (o_dst_fall_back |=> !o_dst_fall_back [*2]) // [R01]
    else $error("fall back repeated");
  a_dst_off: assert property (!cfg_r[`CFG_DSE] |=> !o_dst_fall_back && !o_dst_spring_forward)
    else $error("summer time step while disabled"); // [R02]
  a_apb_ready: assert property (setup |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle after setup");

  // the other two event sources must never be lost either
  a_update_sets: assert property (i_update_end |=> evt_r[`EVT_UF]) // [R14]
    else $error("update event lost");

  a_period_sets: assert property (i_periodic_event |=> evt_r[`EVT_PF]) // [R16]
    else $error("periodic event lost");

  // crystal wave reaches the pin one cycle late, through the output flop
  a_crystal_pin: assert property (cfg_r[`CFG_WAVE_OUT_ENABLE] && evt_r[`EVT_KOUT] |=> // [R13]
    o_wave_out_pin == $past(i_crystal_wave))
    else $error("crystal wave not on pin");

  // a locked event register must ignore the host, so quiet flags stay put
  a_evt_locked: assert property (access_done && i_pwrite && (idx == `RTC_IDX_EVT) // [R21]
    && !osc_is_011 && !i_update_end && !i_alarm_event && !i_periodic_event
    |=> $stable(evt_r[6:4]))
    else $error("locked event register took a write");

  // unused integrity bits and upper lanes always read as zero
  a_valid_zeros: assert property (setup && !i_pwrite && (idx == `RTC_IDX_VALID) // [R18]
    |=> o_prdata[6:0] == 7'h00 && o_prdata[31:8] == 24'h000000)
    else $error("integrity register unused bits set");

  c_alarm_irq: cover property (i_alarm_event && cfg_r[`CFG_AIE] ##2 !o_irq_n);
  c_read_clear: cover property (rd_evt_r && access_done && prdata_r[`EVT_IRQ_REQUEST_FLAG]);
  c_fall_back: cover property (o_dst_fall_back);
  c_crystal_wave: cover property (cfg_r[`CFG_WAVE_OUT_ENABLE] && evt_r[`EVT_KOUT]);

endmodule : rtc_ctrl_regs

`default_nettype wire

/* File: tb/rtc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// apb master standing in for the host; one transfer at a time
module rtc_host_model (
  input  wire logic        i_clock,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  // bus idle at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end

  // request held until pready is seen; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clock);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : rtc_host_model

`default_nettype wire

/* File: tb/tb.sv */
`include "rtc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(g, e)

module tb;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  logic [2:0]  ev = 3'h0;
  logic        tick = 1'b0, cw = 1'b0, rw = 1'b0, bv = 1'b0;
  logic [7:0]  month = 8'h01, date = 8'h01;
  wire         irq_n, wave, allow, hfs, nfs, fall, spring;
  wire  [3:0]  rsel;
  wire  [2:0]  oscf;
  int          n_errors = 0, checked = 0, k, en;
  logic [31:0] q, v;
  logic        e, f, s;
  int          ebit[3] = '{`CFG_AIE, `CFG_PIE, `CFG_UIE};
  int          fbit[3] = '{`EVT_AF, `EVT_PF, `EVT_UF};

  always #50 i_clock = ~i_clock;

  rtc_host_model u_host (.i_clock(i_clock), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));

  // counters hold 01:59:59 in binary so only the date decides summer time
  rtc_ctrl_regs u_rtc_ctrl_regs (.i_clock(i_clock), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_update_busy(1'b0),
    .i_update_end(ev[2]), .i_alarm_event(ev[0]), .i_periodic_event(ev[1]),
    .i_second_tick(tick), .i_cal_hour(8'h01), .i_cal_min(8'h3b), .i_cal_sec(8'h3b),
    .i_cal_dow(8'h01), .i_cal_date(date), .i_cal_month(month), .i_rate_wave(rw),
    .i_crystal_wave(cw), .i_backup_valid(bv), .o_irq_n(irq_n), .o_wave_out_pin(wave),
    .o_update_copy_allow(allow), .o_hour_format_sel(hfs), .o_number_format_sel(nfs),
    .o_rate_select(rsel), .o_osc_control_field(oscf), .o_dst_fall_back(fall),
    .o_dst_spring_forward(spring));

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : check

  // flags expected after one event: its own flag, plus the irq flag when enabled
  function automatic logic [31:0] exp_flags(input int k, input int en);
    exp_flags = (32'h1 << fbit[k]) | (32'(en) << `EVT_IRQ_REQUEST_FLAG);
  endfunction : exp_flags

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        x;
    u_host.xfer(1'b1, a, {24'h0, d}, r, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic x);
    u_host.xfer(1'b0, a, 32'h0, r, x);
  endtask : rd

  // one-cycle event pulse from the counter side
  task automatic pulse(input int i);
    @(posedge i_clock);
    ev[i] <= 1'b1;
    @(posedge i_clock);
    ev <= 3'h0;
  endtask : pulse

  // a pulse may land on any of the next few edges, so collect it
  task automatic dst(input logic [7:0] m, input logic [7:0] d);
    @(posedge i_clock);
    month <= m;
    date <= d;
    tick <= 1'b1;
    @(posedge i_clock);
    tick <= 1'b0;
    f = 0;
    s = 0;
    repeat (4) begin
      @(posedge i_clock);
      f |= fall;
      s |= spring;
    end
  endtask : dst

  task automatic report_and_stop;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // watchdog at 20000 cycles, well beyond the two hundred or so cycles the tests need
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h4fbb));
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    bv <= 1'b1;
    rd(8'h2c, q, e); `CHK(q, 0);
    rd(8'h34, q, e); `CHK(q, 32'h80);
    wr(8'h34, 8'h00);
    bv <= 1'b0;
    repeat (3) @(posedge i_clock); // let the two-flop synchroniser catch up
    rd(8'h34, q, e); `CHK(q, 0);
    rd(8'h3c, q, e); `CHK({e, q}, 33'h100000000);
    // random configurations read back and reach the format outputs
    repeat (4) begin
      v = $urandom & 32'h7f;
      wr(8'h2c, v[7:0]);
      rd(8'h2c, q, e); `CHK(q, v);
      `CHK({hfs, nfs, allow}, {v[1], v[2], 1'b1});
    end
    wr(8'h2c, 8'h90);
    rd(8'h2c, q, e); `CHK(q, 32'h80);
    `CHK(allow, 0);
    // each event source with its enable off and on
    for (k = 0; k < 3; k++) begin
      for (en = 0; en < 2; en++) begin
        wr(8'h2c, 8'(en << ebit[k]));
        pulse(k);
        repeat (2) @(posedge i_clock);
        `CHK(irq_n, !en);
        rd(8'h30, q, e); `CHK(q, exp_flags(k, en));
        rd(8'h30, q, e); `CHK(q, 0);
        `CHK(irq_n, 1);
      end
    end
    // event register writable only with oscillator field 011
    wr(8'h30, 8'hff);
    rd(8'h30, q, e); `CHK(q, 0);
    wr(8'h28, 8'h30);
    wr(8'h30, 8'hff);
    rd(8'h30, q, e); `CHK(q, 32'hf4);
    rd(8'h30, q, e); `CHK(q, 32'h04);
    wr(8'h2c, 8'h08);
    cw <= 1'b1;
    repeat (3) @(posedge i_clock);
    `CHK(wave, 1);
    wr(8'h28, 8'h25);
    rd(8'h30, q, e); `CHK(q, 0);
    `CHK({oscf, rsel}, 7'h25);
    rw <= 1'b1;
    cw <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK(wave, 1);
    wr(8'h2c, 8'h00);
    repeat (3) @(posedge i_clock);
    `CHK(wave, 0);
    // summer time: binary 24 hour counters sitting at 01:59:59 on a sunday
    wr(8'h2c, 8'h07);
    dst(8'h0a, 8'h1a); `CHK({f, s}, 2'b10);
    dst(8'h0a, 8'h14); `CHK({f, s}, 2'b00);
    dst(8'h04, 8'h03); `CHK({f, s}, 2'b01);
    wr(8'h2c, 8'h06);
    dst(8'h04, 8'h02); `CHK({f, s}, 2'b00);
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
